// *** core/wtl_pkg.sv ***
// Constants and types shared by the interval timer and display driver
// Contract
// - Interval timer counts only while its enable bit 1 is set.
// - Overflow reaches the interrupt output only while enable bit 6 is set.
// - Pending bit 0 set by hardware each interval; only software clears it by zero.
// - Speed field bits 3:2 picks 1 s, 0.5 s, 0.25 s or 3.91 ms.
// - Buzzer pin carries a steady 0.5, 1, 2 or 4 kHz square tone.
// - Display frame clock comes from the timer; timer off stops the display.
// - Timer counts from the main clock or from the subsystem clock.
// - Timer control register resets to 00h: timer, interrupt, buzzer off.
// - At most 256 dots: 32 segment lines by 8 common lines.
// - Display memory is fetched to the segment outputs without processor help.
// - Display data lives in page 15, byte and bit access; one lights a dot.
// - Segment k uses byte F00h+k up to F25h; bit n feeds common n.
// - Unused display memory bytes stay ordinary read/write storage.
// - On subsystem clock the display keeps running with main logic idle.
// - Display control register resets to 00h: off, 1/8 duty, 1/4 bias, 128 Hz.
// - Display control holds duty, bias, clock, on/off and divider choice.
// - Duty sets active commons 8/4/3/2; spare shared pins become segments.
// - Dot one gives select on its segment in its common slot, zero no-select.
// - Frame clock sets scan rate; software keeps the timer on with display.
package wtl_pkg;
  localparam logic [7:0] DCTL_OFS      = 8'hd0;
  localparam logic [7:0] TMCTL_OFS     = 8'hd1;
  localparam logic [7:0] DCTL_RST      = 8'h00;
  localparam logic [7:0] TMCTL_RST     = 8'h00;
  localparam logic [7:0] SEG_FIRST_OFS = 8'h00;
  localparam logic [7:0] SEG_LAST_OFS  = 8'h25;
  localparam int WT_PEND_BIT  = 0;
  localparam int WT_EN_BIT    = 1;
  localparam int WT_SPD_LSB   = 2;
  localparam int WT_TONE_LSB  = 4;
  localparam int WT_IE_BIT    = 6;
  localparam int WT_CLK_BIT   = 7;
  localparam int LC_ON_BIT    = 0;
  localparam int LC_CLK_LSB   = 1;
  localparam int LC_DUTY_LSB  = 3;
  localparam int LC_BIAS_LSB  = 5;
  localparam int LC_EXTR_BIT  = 7;
  localparam int NUM_SEG      = 38;
  localparam int NUM_COM      = 8;
  localparam int NUM_SHARED   = 6;
  localparam int MCLK_HZ      = 125_000_000;
  localparam int TICK_HZ      = 32768;
  localparam int MAIN_DIV_CNT = MCLK_HZ / TICK_HZ;
  localparam int INT_SLOW_MS  = 1000;
  localparam int INT_HALF_MS  = 500;
  localparam int INT_QRT_MS   = 250;
  localparam int INT_HS_US    = 3910;
  localparam int CNT_W        = $clog2(INT_SLOW_MS * TICK_HZ / 1000);
  localparam int W_SLOW = $clog2(INT_SLOW_MS * TICK_HZ / 1000);
  localparam int W_HALF = $clog2(INT_HALF_MS * TICK_HZ / 1000);
  localparam int W_QRT  = $clog2(INT_QRT_MS * TICK_HZ / 1000);
  localparam int W_HS   = $clog2(INT_HS_US * TICK_HZ / 1_000_000);
  localparam int TONE_BIT_500  = $clog2(TICK_HZ / (2 * 500));
  localparam int TONE_BIT_1K   = $clog2(TICK_HZ / (2 * 1000));
  localparam int TONE_BIT_2K   = $clog2(TICK_HZ / (2 * 2000));
  localparam int TONE_BIT_4K   = $clog2(TICK_HZ / (2 * 4000));
  localparam int W_FRM_128 = $clog2(TICK_HZ / 128);
  localparam int W_FRM_64  = $clog2(TICK_HZ / 64);
  localparam int W_FRM_256 = $clog2(TICK_HZ / 256);
  localparam int W_FRM_512 = $clog2(TICK_HZ / 512);
  typedef enum logic [1:0] {
    WTL_DUTY_8 = 2'b00,
    WTL_DUTY_4 = 2'b01,
    WTL_DUTY_3 = 2'b10,
    WTL_DUTY_2 = 2'b11
  } wtl_duty_t;
endpackage : wtl_pkg

// *** core/wtl_timer_lcd.sv ***
// Interval timer with buzzer tone and multiplexed display driver
`timescale 1ns/1ns
module wtl_timer_lcd #(
  parameter int MAIN_DIV  = wtl_pkg::MAIN_DIV_CNT,
  parameter int RAM_DEPTH = 256
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  // Subsystem clock pin, sampled as a level
  input  wire logic         sub_clk_i,
  // Control register port
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic         reg_wr_i,
  input  wire logic [7:0]   reg_wdata_i,
  output logic      [7:0]   reg_rdata_o,
  // Display memory port, page 15
  input  wire logic [7:0]   ram_addr_i,
  input  wire logic         ram_wr_i,
  input  wire logic [7:0]   ram_wdata_i,
  output logic      [7:0]   ram_rdata_o,
  // Timer outputs
  output logic              timer_interrupt_level_o,
  output logic              tone_output_pin_o,
  output logic              display_frame_clock_o,
  // Display pins
  output logic      [7:0]   common_lines_o,
  output logic      [37:6]  segment_lines_o,
  output logic      [5:0]   shared_is_segment_o,
  output logic              frame_polarity_o,
  output logic      [1:0]   bias_select_o,
  output logic              divider_enable_o
);

  if (MAIN_DIV < 2 || MAIN_DIV > 4096)
  begin : g_div_chk
    $error("MAIN_DIV out of range");
  end
  if (RAM_DEPTH != 256)
  begin : g_ram_chk
    $error("RAM_DEPTH must be one full page");
  end

  // True when the low n bits of v are all ones
  function automatic logic low_ones(input logic [14:0] v, input int n);
    logic [14:0] m;
    m = 15'((32'd1 << n) - 32'd1);
    return &(v | ~m);
  endfunction : low_ones

  function automatic logic [3:0] duty_commons(input wtl_pkg::wtl_duty_t d);
    logic [3:0] n;
    n = 4'h8;
    unique case (d)
      wtl_pkg::WTL_DUTY_8: n = 4'h8;
      wtl_pkg::WTL_DUTY_4: n = 4'h4;
      wtl_pkg::WTL_DUTY_3: n = 4'h3;
      wtl_pkg::WTL_DUTY_2: n = 4'h2;
    endcase
    return n;
  endfunction : duty_commons

  // Registers
  logic [7:0]   tmctl_r;
  logic [7:0]   tmctl_nxt;
  logic [7:0]   dctl_r;
  logic [7:0]   ram_r [RAM_DEPTH];
  logic [14:0]  cnt_r;
  logic [11:0]  div_r;
  logic         sub_s1_r;
  logic         sub_s2_r;
  logic         sub_s3_r;
  logic [2:0]   com_idx_r;
  logic         frame_pol_r;
  logic [7:0]   reg_rdata_r;
  logic [7:0]   ram_rdata_r;
  logic         tone_r;
  logic         frame_clk_r;
  logic [7:0]   com_r;
  logic [37:6]  seg_r;
  logic         div_en_r;

  // Decode
  wire          wr_tmctl   = reg_wr_i && (reg_addr_i == wtl_pkg::TMCTL_OFS);
  wire          wr_dctl    = reg_wr_i && (reg_addr_i == wtl_pkg::DCTL_OFS);
  wire          tmr_run    = tmctl_r[wtl_pkg::WT_EN_BIT];
  wire          use_sub    = tmctl_r[wtl_pkg::WT_CLK_BIT];
  wire [1:0]    spd_sel    = tmctl_r[wtl_pkg::WT_SPD_LSB +: 2];
  wire [1:0]    tone_sel   = tmctl_r[wtl_pkg::WT_TONE_LSB +: 2];
  wire          disp_on    = dctl_r[wtl_pkg::LC_ON_BIT];
  wire [1:0]    frm_sel    = dctl_r[wtl_pkg::LC_CLK_LSB +: 2];
  wire          ext_res    = dctl_r[wtl_pkg::LC_EXTR_BIT];
  wire wtl_pkg::wtl_duty_t duty = wtl_pkg::wtl_duty_t'(dctl_r[wtl_pkg::LC_DUTY_LSB +: 2]);
  wire [3:0]    ncom       = duty_commons(duty);

  // Timer clock source: main divider tick or subsystem clock edge
  wire          main_tick  = (div_r == 12'(MAIN_DIV - 1));
  wire          sub_tick   = sub_s2_r && !sub_s3_r;
  wire          tk_tick    = tmr_run && (use_sub ? sub_tick : main_tick);

  wire          interval_evt =
    tk_tick && ((spd_sel == 2'b00) ? low_ones(cnt_r, wtl_pkg::W_SLOW) :
                (spd_sel == 2'b01) ? low_ones(cnt_r, wtl_pkg::W_HALF) :
                (spd_sel == 2'b10) ? low_ones(cnt_r, wtl_pkg::W_QRT)  :
                                     low_ones(cnt_r, wtl_pkg::W_HS));

  wire          tone_bit =
    (tone_sel == 2'b00) ? cnt_r[wtl_pkg::TONE_BIT_500] :
    (tone_sel == 2'b01) ? cnt_r[wtl_pkg::TONE_BIT_1K]  :
    (tone_sel == 2'b10) ? cnt_r[wtl_pkg::TONE_BIT_2K]  :
                          cnt_r[wtl_pkg::TONE_BIT_4K];

  // Frame clock taps the timer counter, so a halted timer stops the scan and resets it to slot 0
  wire          frame_tick =
    tk_tick && ((frm_sel == 2'b00) ? low_ones(cnt_r, wtl_pkg::W_FRM_128) :
                (frm_sel == 2'b01) ? low_ones(cnt_r, wtl_pkg::W_FRM_64)  :
                (frm_sel == 2'b10) ? low_ones(cnt_r, wtl_pkg::W_FRM_256) :
                                     low_ones(cnt_r, wtl_pkg::W_FRM_512));

  // Scanning only while both the display and its clock source run
  wire          disp_active = disp_on && tmr_run;
  // An index left over from a wider duty acts as slot 0, so no blank slots follow
  wire          idx_out     = ({1'b0, com_idx_r} >= ncom);
  wire [2:0]    scan_idx    = idx_out ? 3'h0 : com_idx_r;
  wire          last_com    = ({1'b0, scan_idx} == (ncom - 4'h1));

  // Pending bit: software may only clear it, and a new event wins
  always_comb
  begin
    tmctl_nxt = tmctl_r;
    if (wr_tmctl)
    begin
      tmctl_nxt = reg_wdata_i;
      tmctl_nxt[wtl_pkg::WT_PEND_BIT] = tmctl_r[wtl_pkg::WT_PEND_BIT]
                                        && reg_wdata_i[wtl_pkg::WT_PEND_BIT];
    end
    if (interval_evt)
      tmctl_nxt[wtl_pkg::WT_PEND_BIT] = 1'b1;
  end

  assign timer_interrupt_level_o = tmctl_r[wtl_pkg::WT_IE_BIT]
                                   && tmctl_r[wtl_pkg::WT_PEND_BIT];

  // Control registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      tmctl_r <= wtl_pkg::TMCTL_RST;
      dctl_r  <= wtl_pkg::DCTL_RST;
    end
    else
    begin
      tmctl_r <= tmctl_nxt;
      if (wr_dctl)
        dctl_r <= reg_wdata_i;
    end
  end

  // Subsystem clock synchroniser and edge detect
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sub_s1_r <= 1'b0;
      sub_s2_r <= 1'b0;
      sub_s3_r <= 1'b0;
    end
    else
    begin
      sub_s1_r <= sub_clk_i;
      sub_s2_r <= sub_s1_r;
      sub_s3_r <= sub_s2_r;
    end
  end

  // Main clock prescaler and timer counter
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      div_r <= 12'h000;
      cnt_r <= 15'h0000;
    end
    else
    begin
      div_r <= main_tick ? 12'h000 : div_r + 12'h001;
      if (tk_tick)
        cnt_r <= cnt_r + 15'h0001;
    end
  end

  // Tone and frame clock outputs
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      tone_r      <= 1'b0;
      frame_clk_r <= 1'b0;
    end
    else
    begin
      tone_r      <= tmr_run && tone_bit;
      frame_clk_r <= frame_tick;
    end
  end

  // Common scan; subsystem ticks keep it going when main logic is idle
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !disp_active)
    begin
      com_idx_r   <= 3'h0;
      frame_pol_r <= 1'b0;
    end
    else if (frame_tick)
    begin
      if (last_com)
      begin
        com_idx_r   <= 3'h0;
        frame_pol_r <= !frame_pol_r;
      end
      else
        com_idx_r <= scan_idx + 3'h1;
    end
  end

  // Display memory; every byte is plain storage as well
  always_ff @(posedge mclk_i)
  begin
    if (ram_wr_i)
      ram_r[ram_addr_i] <= ram_wdata_i;
  end

  // Read data, one cycle after the address
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_r <= 8'h00;
      ram_rdata_r <= 8'h00;
    end
    else
    begin
      reg_rdata_r <= (reg_addr_i == wtl_pkg::TMCTL_OFS) ? tmctl_r :
                     (reg_addr_i == wtl_pkg::DCTL_OFS)  ? dctl_r  : 8'h00;
      ram_rdata_r <= ram_r[ram_addr_i];
    end
  end

  // Line drive: fetched straight from memory for the current common slot
  logic [7:0]   com_nxt;
  logic [37:0]  seg_nxt;
  always_comb
  begin
    com_nxt = 8'h00;
    seg_nxt = 38'h0;
    for (int j = 0; j < wtl_pkg::NUM_COM; j++)
      com_nxt[j] = disp_active && (j < int'(ncom)) && (scan_idx == 3'(j));
    for (int k = 0; k < wtl_pkg::NUM_SEG; k++)
      seg_nxt[k] = disp_active
                   && ram_r[8'(wtl_pkg::SEG_FIRST_OFS + 8'(k))][scan_idx];
    // Shared pin COM(k+2)/SEG(k) carries segment data when its common is unused
    for (int k = 0; k < wtl_pkg::NUM_SHARED; k++)
      if ((k + 2) >= int'(ncom))
        com_nxt[k + 2] = seg_nxt[k];
  end

  logic [5:0]   shared_seg;
  always_comb
  begin
    shared_seg = 6'h00;
    for (int k = 0; k < wtl_pkg::NUM_SHARED; k++)
      shared_seg[k] = ((k + 2) >= int'(ncom));
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      com_r    <= 8'h00;
      seg_r    <= '0;
      div_en_r <= 1'b0;
    end
    else
    begin
      com_r    <= com_nxt;
      seg_r    <= seg_nxt[37:6];
      div_en_r <= disp_on && !ext_res;
    end
  end

  assign reg_rdata_o           = reg_rdata_r;
  assign ram_rdata_o           = ram_rdata_r;
  assign tone_output_pin_o     = tone_r;
  assign display_frame_clock_o = frame_clk_r;
  assign common_lines_o        = com_r;
  assign segment_lines_o       = seg_r;
  assign shared_is_segment_o   = shared_seg;
  assign frame_polarity_o      = frame_pol_r;
  assign bias_select_o         = dctl_r[wtl_pkg::LC_BIAS_LSB +: 2];
  assign divider_enable_o      = div_en_r;

  // Checks
  chk_timer_halt: assert property (@(posedge mclk_i) disable iff (rst_i)
    !tmr_run |=> $stable(cnt_r))
    else $error("timer counted while disabled");

  chk_irq_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer_interrupt_level_o |-> tmctl_r[6] && tmctl_r[0])
    else $error("interrupt raised without enable and pending");

  chk_pend_set: assert property (@(posedge mclk_i) disable iff (rst_i)
    interval_evt |=> tmctl_r[0])
    else $error("pending not set by interval event");

  chk_pend_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
    tmctl_r[0] && !(wr_tmctl && !reg_wdata_i[0]) |=> tmctl_r[0])
    else $error("pending cleared by hardware");

  chk_hs_interval: assert property (@(posedge mclk_i) disable iff (rst_i)
    interval_evt && spd_sel == 2'b11 |-> cnt_r[6:0] == 7'h7f)
    else $error("high speed interval wrong");

  chk_reset_regs: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(rst_i) |-> tmctl_r == 8'h00 && dctl_r == 8'h00)
    else $error("control registers not cleared by reset");

  chk_off_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    !disp_on ##1 !disp_on |-> com_r == 8'h00 && seg_r == '0 && !div_en_r)
    else $error("display lines driven while off");

  chk_scan_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
    disp_active && frame_tick && last_com ##1 disp_active |-> com_idx_r == 3'h0)
    else $error("scan did not restart after last common");

  chk_frame_stop: assert property (@(posedge mclk_i) disable iff (rst_i)
    !tmr_run |=> com_idx_r == 3'h0 && !display_frame_clock_o)
    else $error("display ran with timer off");

  chk_seg_data: assert property (@(posedge mclk_i) disable iff (rst_i)
    disp_active && !ram_wr_i |=> seg_r[6] == $past(ram_r[6][scan_idx]))
    else $error("segment does not follow memory bit");

  chk_duty_commons: assert property (@(posedge mclk_i) disable iff (rst_i)
    disp_active && duty == wtl_pkg::WTL_DUTY_2 |=> com_r[1:0] != 2'b00)
    else $error("two common duty lost its commons");

  cov_pend: cover property (@(posedge mclk_i) disable iff (rst_i)
    interval_evt && tmctl_r[6]);
  cov_wrap: cover property (@(posedge mclk_i) disable iff (rst_i)
    disp_active && frame_tick && last_com);
  cov_tone: cover property (@(posedge mclk_i) disable iff (rst_i)
    $rose(tone_output_pin_o));
  cov_sub_scan: cover property (@(posedge mclk_i) disable iff (rst_i)
    use_sub && disp_active && frame_tick);

endmodule : wtl_timer_lcd

// *** tb/wtl_panel_model.sv ***
// Panel and buzzer side: free-running subsystem crystal and tone period meter
`timescale 1ns/1ns
module wtl_panel_model #(
  parameter int SUB_HALF = 5
) (
  input  wire logic mclk_i,
  input  wire logic tone_i,
  output logic      sub_clk_o,
  output int        tone_period_o
);
  int   div_cnt = 0;
  int   cyc     = 0;
  int   last    = 0;
  logic tone_q  = 1'b0;
  initial sub_clk_o = 1'b0;
  initial tone_period_o = 0;
  // The watch crystal runs free, whatever the main logic is doing
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    div_cnt <= (div_cnt == SUB_HALF - 1) ? 0 : div_cnt + 1;
    if (div_cnt == SUB_HALF - 1)
      sub_clk_o <= ~sub_clk_o;
    tone_q <= tone_i;
    if (tone_i && !tone_q)
    begin
      tone_period_o <= cyc - last;
      last <= cyc;
    end
  end
endmodule : wtl_panel_model

// *** tb/wtl_timer_lcd_bench.sv ***
// Self-checking bench for the interval timer and display driver
`timescale 1ns/1ns
module wtl_timer_lcd_bench;
  localparam int MDIV  = 2;
  localparam int SUBH  = 5;
  localparam int LIMIT = 100000;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        sub_clk;
  logic [7:0]  raddr = 8'h00;
  logic        rwr = 1'b0;
  logic [7:0]  rwd = 8'h00;
  logic [7:0]  rrd;
  logic [7:0]  maddr = 8'h00;
  logic        mwr = 1'b0;
  logic [7:0]  mwd = 8'h00;
  logic [7:0]  mrd;
  logic        irq;
  logic        tone;
  logic        frm;
  logic [7:0]  com;
  logic [37:6] seg;
  logic [5:0]  shr;
  logic        pol;
  logic [1:0]  bias;
  logic        divider;
  int          tone_period;
  int          cyc = 0;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #4 mclk = ~mclk;

  wtl_timer_lcd #(.MAIN_DIV(MDIV)) u_dut (
    .mclk_i(mclk), .rst_i(rst), .sub_clk_i(sub_clk),
    .reg_addr_i(raddr), .reg_wr_i(rwr), .reg_wdata_i(rwd), .reg_rdata_o(rrd),
    .ram_addr_i(maddr), .ram_wr_i(mwr), .ram_wdata_i(mwd), .ram_rdata_o(mrd),
    .timer_interrupt_level_o(irq), .tone_output_pin_o(tone),
    .display_frame_clock_o(frm), .common_lines_o(com), .segment_lines_o(seg),
    .shared_is_segment_o(shr), .frame_polarity_o(pol), .bias_select_o(bias),
    .divider_enable_o(divider)
  );

  wtl_panel_model #(.SUB_HALF(SUBH)) u_panel (
    .mclk_i(mclk), .tone_i(tone), .sub_clk_o(sub_clk), .tone_period_o(tone_period)
  );

  task automatic stop_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] pat(input int k);
    return 8'(k) ^ 8'ha5;
  endfunction : pat

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    raddr = a;
    rwd = d;
    rwr = 1'b1;
    @(negedge mclk);
    rwr = 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    raddr = a;
    @(negedge mclk);
    d = rrd;
  endtask : rreg

  task automatic wram(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    maddr = a;
    mwd = d;
    mwr = 1'b1;
    @(negedge mclk);
    mwr = 1'b0;
  endtask : wram

  task automatic rram(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    maddr = a;
    @(negedge mclk);
    d = mrd;
  endtask : rram

  // Software clears pending by writing zero, then the next set is timed
  task automatic irq_gap(input logic [7:0] ctl, output int gap);
    int t0;
    while (irq !== 1'b1) @(posedge mclk);
    t0 = cyc;
    wreg(8'hd1, ctl);
    while (irq !== 1'b1) @(posedge mclk);
    gap = cyc - t0;
  endtask : irq_gap

  task automatic frame_gap(output int gap);
    int t0;
    while (frm !== 1'b1) @(posedge mclk);
    t0 = cyc;
    @(posedge mclk);
    while (frm !== 1'b1) @(posedge mclk);
    gap = cyc - t0;
  endtask : frame_gap

  task automatic t_reset;
    logic [7:0] d;
    rreg(8'hd0, d);
    chk("disp_ctl", d, 8'h00);
    rreg(8'hd1, d);
    chk("tmr_ctl", d, 8'h00);
    rreg(8'h55, d);
    chk("unmapped", d, 8'h00);
    chk("pins", {irq, tone, frm, divider, com}, 32'h0);
    chk("segs", seg, 32'h0);
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] d;
    logic [5:0] shr_exp [4] = '{6'h00, 6'h3c, 6'h3e, 6'h3f};
    wreg(8'hd0, 8'h60);
    rreg(8'hd0, d);
    chk("disp_rb", d, 8'h60);
    chk("bias", bias, 2'b11);
    for (int i = 0; i < 4; i++)
    begin
      wreg(8'hd0, 8'(i << 3));
      chk("shared", shr, shr_exp[i]);
    end
    wreg(8'hd1, 8'h01);
    rreg(8'hd1, d);
    chk("pend_set", d, 8'h00);
  endtask : t_regs

  task automatic t_ram;
    logic [7:0] d;
    wram(8'hff, 8'h3c);
    rram(8'hff, d);
    chk("spare_ram", d, 8'h3c);
    for (int k = 0; k < 38; k++)
      wram(8'(k), pat(k));
    rram(8'h25, d);
    chk("disp_ram", d, pat(37));
  endtask : t_ram

  task automatic t_timer;
    logic [7:0] d;
    int         g;
    wreg(8'hd1, 8'h7c);
    repeat (600) @(negedge mclk);
    rreg(8'hd1, d);
    chk("halted", {d, irq, tone}, {8'h7c, 2'b00});
    wreg(8'hd1, 8'h4e);
    irq_gap(8'h4e, g);
    chk("gap_fast", g, 128 * MDIV);
    wreg(8'hd1, 8'h4a);
    irq_gap(8'h4a, g);
    chk("gap_qrt", g, 8192 * MDIV);
    wreg(8'hd1, 8'h0e);
    repeat (300) @(negedge mclk);
    rreg(8'hd1, d);
    chk("pend_poll", {d, irq}, {8'h0f, 1'b0});
    wreg(8'hd1, 8'h4f);
    chk("irq_on", irq, 1'b1);
    wreg(8'hd1, 8'hce);
    irq_gap(8'hce, g);
    chk("gap_sub", g, 128 * 2 * SUBH);
  endtask : t_timer

  task automatic t_tone;
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'hd1, 8'(8'h02 | (c << 4)));
      repeat (300) @(negedge mclk);
      chk("tone", tone_period, (2 ** (6 - c)) * MDIV);
    end
  endtask : t_tone

  task automatic t_frame;
    int g;
    int ticks [4] = '{256, 512, 128, 64};
    wreg(8'hd1, 8'h02);
    for (int c = 0; c < 4; c++)
    begin
      wreg(8'hd0, 8'(8'h01 | (c << 1)));
      frame_gap(g);
      frame_gap(g);
      chk("frame", g, ticks[c] * MDIV);
    end
  endtask : t_frame

  // Half duty: commons 0 and 1 alternate, shared pins carry segments 0 to 5
  task automatic t_scan;
    logic [37:6] es;
    logic [7:0]  ec;
    logic [7:0]  b;
    int          idx;
    wreg(8'hd0, 8'h1f);
    for (int f = 0; f < 4; f++)
    begin
      while (frm !== 1'b1) @(posedge mclk);
      repeat (3) @(negedge mclk);
      idx = (f == 0) ? int'(com[1]) : 1 - idx;
      ec = 8'(1 << idx);
      for (int j = 2; j < 8; j++)
      begin
        b = pat(j - 2);
        ec[j] = b[idx];
      end
      for (int k = 6; k < 38; k++)
      begin
        b = pat(k);
        es[k] = b[idx];
      end
      chk("commons", com, ec);
      chk("segments", seg, es);
    end
    chk("divider_on", divider, 1'b1);
  endtask : t_scan

  task automatic t_off;
    int n;
    wreg(8'hd0, 8'h1e);
    repeat (3) @(negedge mclk);
    chk("off_pins", {com, divider}, 9'h000);
    chk("off_segs", seg, 32'h0);
    wreg(8'hd0, 8'h9f);
    repeat (3) @(negedge mclk);
    chk("ext_div", divider, 1'b0);
    wreg(8'hd1, 8'h00);
    repeat (3) @(negedge mclk);
    chk("tmr_off_com", com, 8'h00);
    n = 0;
    repeat (300)
    begin
      @(posedge mclk);
      if (frm === 1'b1)
        n++;
    end
    chk("tmr_off_frm", n, 0);
  endtask : t_off

  initial
  begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_ram();
    t_timer();
    t_tone();
    t_frame();
    t_scan();
    t_off();
    stop_test();
  end
endmodule : wtl_timer_lcd_bench
